// ### rtl/prr_defines.svh
/*
  Offsets, field positions, reset values and the FIFO depth of the
  pressure result register block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef PRR_DEFINES_SVH
`define PRR_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define PRR_OFS_REF_HIGH      8'h16
`define PRR_OFS_TRIM_LOW      8'h18
`define PRR_OFS_TRIM_HIGH     8'h19
`define PRR_OFS_IRQ_CAUSE     8'h24
`define PRR_OFS_FIFO_COUNT    8'h25
`define PRR_OFS_FIFO_FLAGS    8'h26
`define PRR_OFS_SAMPLE_STATE  8'h27
`define PRR_OFS_PRES_LOW      8'h28
`define PRR_OFS_PRES_MID      8'h29
`define PRR_OFS_PRES_HIGH     8'h2A
`define PRR_OFS_TEMP_LOW      8'h2B
`define PRR_OFS_TEMP_HIGH     8'h2C
`define PRR_OFS_FILTER_CLEAR  8'h3C
`define PRR_OFS_QPRES_LOW     8'h78
`define PRR_OFS_QPRES_MID     8'h79
`define PRR_OFS_QPRES_HIGH    8'h7A
`define PRR_OFS_QTEMP_LOW     8'h7B
`define PRR_OFS_QTEMP_HIGH    8'h7C

// ****************************************
// Field positions
// ****************************************
`define PRR_BIT_BOOT_ON       7
`define PRR_BIT_IRQ_ACTIVE    2
`define PRR_BIT_DIFF_LOW      1
`define PRR_BIT_DIFF_HIGH     0
`define PRR_BIT_FIFO_WTM      7
`define PRR_BIT_FIFO_OVR      6
`define PRR_BIT_FIFO_FULL     5
`define PRR_BIT_T_OVR         5
`define PRR_BIT_P_OVR         4
`define PRR_BIT_T_AVAIL       1
`define PRR_BIT_P_AVAIL       0

// ****************************************
// Reset values and sizes
// ****************************************
`define PRR_RST_BYTE          8'h00
`define PRR_RST_WORD16        16'h0000
`define PRR_RST_WORD24        24'h00_0000
`define PRR_FIFO_DEPTH        8'h80
`define PRR_FIFO_AW           7

`endif

// ### rtl/prr_pkg.sv
/*
  Types shared by the pressure result register block.
  Assumes prr_defines.svh is on the include path.
*/
`include "prr_defines.svh"

package prr_pkg;

  // Register port request (read or write)
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prr_req_t;

  // One conversion or stored FIFO sample
  typedef struct packed {
    logic [23:0] pres;
    logic [15:0] temp;
  } prr_sample_t;

  // Result hold state under block-update hold
  typedef enum logic [1:0] {
    PRR_FREE = 2'b00,
    PRR_HELD = 2'b01
  } prr_hold_t;

  typedef struct packed {
    logic [15:0]  offset_trim;
    prr_sample_t  result;
    prr_sample_t  pending;
    logic         pending_valid;
    prr_hold_t    hold;
    logic [2:0]   parts_read;
    logic         t_avail;
    logic         p_avail;
    logic         t_ovr;
    logic         p_ovr;
    logic [7:0]   status_snap;
    logic [7:0]   rdata;
    logic         filter_clear;
    logic         fifo_pop;
    logic [1:0]   fifo_parts;
  } prr_state_t;

endpackage

// ### rtl/prr_result_regs.sv
/*
  Read-side result and status register block of a barometric sensor.
  Assumes a byte-wide register port from the serial interface (one-cycle
  read and write strobes), and that the conversion engine, FIFO core and
  threshold comparator report into this block on REF_CLK.
*/
`timescale 1ns/1ps
`include "prr_defines.svh"

module prr_result_regs (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  // Register port
  input  wire logic        REG_RD,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  // Mode controls
  input  wire logic        BLOCK_UPDATE_HOLD,
  input  wire logic        DELTA_MODE_ENABLE,
  input  wire logic        ZERO_TRACKING_MODE,
  input  wire logic        REF_CAPTURE_MODE,
  // Reference word
  input  wire logic [15:0] REFERENCE_PRESSURE_BITS,
  // Conversion engine
  input  wire logic        NEW_SAMPLE,
  input  wire logic [23:0] MEASURED_PRESSURE,
  input  wire logic [23:0] PROCESSED_PRESSURE,
  input  wire logic [15:0] MEASURED_TEMPERATURE,
  input  wire logic        OUTPUT_RATE_TICK,
  input  wire logic        BOOT_RUNNING,
  // Threshold comparator
  input  wire logic        DIFF_LOW_EVENT,
  input  wire logic        DIFF_HIGH_EVENT,
  input  wire logic        IRQ_ACTIVE_FLAG,
  // FIFO core
  input  wire logic [7:0]  FIFO_LEVEL_COUNT,
  input  wire logic [6:0]  FIFO_THRESHOLD,
  input  wire logic        FIFO_OVERWRITTEN,
  input  wire logic [23:0] FIFO_HEAD_PRESSURE,
  input  wire logic [15:0] FIFO_HEAD_TEMPERATURE,
  output logic             FIFO_POP,
  // Filter control and offset word
  output logic             EXTRA_LOWPASS_FILTER_CLEAR,
  output logic [15:0]      PRESSURE_OFFSET_WORD
);

  prr_pkg::prr_state_t s_q;
  prr_pkg::prr_state_t s_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [23:0] pres_out(input logic [15:0] trim);
    logic [23:0] ext;
    ext = {{8{trim[15]}}, trim};
    if (DELTA_MODE_ENABLE || ZERO_TRACKING_MODE || REF_CAPTURE_MODE) begin
      pres_out = PROCESSED_PRESSURE;
    end else begin
      pres_out = MEASURED_PRESSURE - ext;
    end
  endfunction

  logic       rd_go;
  logic       fifo_full;
  logic [7:0] cause_byte;
  logic [7:0] fifo_flag_byte;
  logic [7:0] live_status;

  assign rd_go     = REG_RD;
  assign fifo_full = (FIFO_LEVEL_COUNT == `PRR_FIFO_DEPTH);

  // ****************************************
  // Live status bytes
  // ****************************************
  always_comb begin
    cause_byte = `PRR_RST_BYTE;
    cause_byte[`PRR_BIT_BOOT_ON]    = BOOT_RUNNING;
    cause_byte[`PRR_BIT_IRQ_ACTIVE] = IRQ_ACTIVE_FLAG;
    cause_byte[`PRR_BIT_DIFF_LOW]   = DIFF_LOW_EVENT;
    cause_byte[`PRR_BIT_DIFF_HIGH]  = DIFF_HIGH_EVENT;
    fifo_flag_byte = `PRR_RST_BYTE;
    fifo_flag_byte[`PRR_BIT_FIFO_WTM] =
      (FIFO_LEVEL_COUNT >= {1'b0, FIFO_THRESHOLD});
    fifo_flag_byte[`PRR_BIT_FIFO_OVR]  = fifo_full && FIFO_OVERWRITTEN;
    fifo_flag_byte[`PRR_BIT_FIFO_FULL] = fifo_full && !FIFO_OVERWRITTEN;
    live_status = `PRR_RST_BYTE;
    live_status[`PRR_BIT_T_OVR]   = s_q.t_ovr;
    live_status[`PRR_BIT_P_OVR]   = s_q.p_ovr;
    live_status[`PRR_BIT_T_AVAIL] = s_q.t_avail;
    live_status[`PRR_BIT_P_AVAIL] = s_q.p_avail;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    prr_pkg::prr_sample_t fresh;
    logic                 lock;
    logic [2:0]           parts;
    logic                 t_rd;
    logic                 p_rd;
    fresh = '0;
    lock  = 1'b0;
    parts = s_q.parts_read;
    t_rd  = 1'b0;
    p_rd  = 1'b0;
    s_d   = s_q;
    s_d.filter_clear = 1'b0;
    s_d.fifo_pop     = 1'b0;

    // Software-written offset trim
    if (REG_WR) begin
      if (hit(REG_ADDR, `PRR_OFS_TRIM_LOW)) begin
        s_d.offset_trim[7:0] = REG_WDATA;
      end
      if (hit(REG_ADDR, `PRR_OFS_TRIM_HIGH)) begin
        s_d.offset_trim[15:8] = REG_WDATA;
      end
    end

    // Read data mux, registered so the byte is stable for the serial shifter
    if (rd_go) begin
      unique case (REG_ADDR)
        `PRR_OFS_REF_HIGH:     s_d.rdata = REFERENCE_PRESSURE_BITS[15:8];
        `PRR_OFS_TRIM_LOW:     s_d.rdata = s_q.offset_trim[7:0];
        `PRR_OFS_TRIM_HIGH:    s_d.rdata = s_q.offset_trim[15:8];
        `PRR_OFS_IRQ_CAUSE:    s_d.rdata = cause_byte;
        `PRR_OFS_FIFO_COUNT:   s_d.rdata = FIFO_LEVEL_COUNT;
        `PRR_OFS_FIFO_FLAGS:   s_d.rdata = fifo_flag_byte;
        `PRR_OFS_SAMPLE_STATE: s_d.rdata = s_q.status_snap;
        `PRR_OFS_PRES_LOW:     s_d.rdata = s_q.result.pres[7:0];
        `PRR_OFS_PRES_MID:     s_d.rdata = s_q.result.pres[15:8];
        `PRR_OFS_PRES_HIGH:    s_d.rdata = s_q.result.pres[23:16];
        `PRR_OFS_TEMP_LOW:     s_d.rdata = s_q.result.temp[7:0];
        `PRR_OFS_TEMP_HIGH:    s_d.rdata = s_q.result.temp[15:8];
        `PRR_OFS_QPRES_LOW:    s_d.rdata = FIFO_HEAD_PRESSURE[7:0];
        `PRR_OFS_QPRES_MID:    s_d.rdata = FIFO_HEAD_PRESSURE[15:8];
        `PRR_OFS_QPRES_HIGH:   s_d.rdata = FIFO_HEAD_PRESSURE[23:16];
        `PRR_OFS_QTEMP_LOW:    s_d.rdata = FIFO_HEAD_TEMPERATURE[7:0];
        `PRR_OFS_QTEMP_HIGH:   s_d.rdata = FIFO_HEAD_TEMPERATURE[15:8];
        default:               s_d.rdata = `PRR_RST_BYTE;
      endcase
    end

    // Filter clear strobe
    if (rd_go && hit(REG_ADDR, `PRR_OFS_FILTER_CLEAR)) begin
      s_d.filter_clear = 1'b1;
    end

    // FIFO sample walk: pop after the last temperature byte closes a sample
    if (rd_go) begin
      if (hit(REG_ADDR, `PRR_OFS_QPRES_LOW)) begin
        s_d.fifo_parts = 2'b01;
      end else if (hit(REG_ADDR, `PRR_OFS_QTEMP_HIGH)) begin
        s_d.fifo_parts = 2'b00;
        s_d.fifo_pop   = (FIFO_LEVEL_COUNT != `PRR_RST_BYTE);
      end
    end

    // Track which result parts were read while held
    if (rd_go) begin
      if (hit(REG_ADDR, `PRR_OFS_PRES_LOW))  parts[0] = 1'b1;
      if (hit(REG_ADDR, `PRR_OFS_PRES_MID))  parts[1] = 1'b1;
      if (hit(REG_ADDR, `PRR_OFS_PRES_HIGH)) parts[2] = 1'b1;
      p_rd = hit(REG_ADDR, `PRR_OFS_PRES_HIGH) || hit(REG_ADDR, `PRR_OFS_PRES_MID)
          || hit(REG_ADDR, `PRR_OFS_PRES_LOW);
      t_rd = hit(REG_ADDR, `PRR_OFS_TEMP_HIGH) || hit(REG_ADDR, `PRR_OFS_TEMP_LOW);
    end

    // Reading a result clears its availability; a new sample still wins
    if (p_rd) begin
      s_d.p_avail = 1'b0;
      s_d.p_ovr   = 1'b0;
    end
    if (t_rd) begin
      s_d.t_avail = 1'b0;
      s_d.t_ovr   = 1'b0;
    end

    // Hold state under block-update hold
    unique case (s_q.hold)
      prr_pkg::PRR_FREE: begin
        parts = 3'b000;
        if (BLOCK_UPDATE_HOLD && rd_go && hit(REG_ADDR, `PRR_OFS_PRES_LOW)) begin
          s_d.hold = prr_pkg::PRR_HELD;
          parts    = 3'b001;
        end
      end
      prr_pkg::PRR_HELD: begin
        if (!BLOCK_UPDATE_HOLD || (parts == 3'b111)) begin
          s_d.hold = prr_pkg::PRR_FREE;
          parts    = 3'b000;
        end
      end
      default: s_d.hold = prr_pkg::PRR_FREE;
    endcase
    s_d.parts_read = parts;
    lock = (s_d.hold == prr_pkg::PRR_HELD);

    // New conversion: held results are parked until the read completes
    fresh.pres = pres_out(s_q.offset_trim);
    fresh.temp = MEASURED_TEMPERATURE;
    if (NEW_SAMPLE) begin
      s_d.p_ovr   = s_q.p_avail || s_d.p_ovr;
      s_d.t_ovr   = s_q.t_avail || s_d.t_ovr;
      s_d.p_avail = 1'b1;
      s_d.t_avail = 1'b1;
      if (lock) begin
        s_d.pending       = fresh;
        s_d.pending_valid = 1'b1;
      end else begin
        s_d.result        = fresh;
        s_d.pending_valid = 1'b0;
      end
    end else if (!lock && s_q.pending_valid) begin
      s_d.result        = s_q.pending;
      s_d.pending_valid = 1'b0;
    end

    // Status snapshot refreshed on each output rate period
    if (OUTPUT_RATE_TICK) begin
      s_d.status_snap = live_status;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA                  = s_q.rdata;
  assign FIFO_POP                   = s_q.fifo_pop;
  assign EXTRA_LOWPASS_FILTER_CLEAR = s_q.filter_clear;
  assign PRESSURE_OFFSET_WORD       = s_q.offset_trim;

endmodule

// ### test/prr_chk.sv
/* Checker of the result register block's read port and strobes.
   Assumes a bind onto prr_result_regs, one clock REF_CLK. */
`timescale 1ns/1ps
module prr_chk (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SRST,
  // Register port
  input wire logic        REG_RD,
  input wire logic        REG_WR,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  // Reference word and live status sources
  input wire logic [15:0] REFERENCE_PRESSURE_BITS,
  input wire logic        BOOT_RUNNING,
  input wire logic        DIFF_LOW_EVENT,
  input wire logic        DIFF_HIGH_EVENT,
  input wire logic        IRQ_ACTIVE_FLAG,
  input wire logic [7:0]  FIFO_LEVEL_COUNT,
  input wire logic [6:0]  FIFO_THRESHOLD,
  input wire logic        FIFO_OVERWRITTEN,
  // Outputs
  input wire logic        FIFO_POP,
  input wire logic        EXTRA_LOWPASS_FILTER_CLEAR,
  input wire logic [15:0] PRESSURE_OFFSET_WORD
);
  // ****************************************
  // Inputs seen at the read edge
  // ****************************************
  logic [7:0] ref_q;
  logic [7:0] cause_q;
  logic [7:0] lvl_q;
  logic [2:0] fl_q;
  always_ff @(posedge REF_CLK) begin
    ref_q   <= REFERENCE_PRESSURE_BITS[15:8];
    cause_q <= {BOOT_RUNNING, 4'h0, IRQ_ACTIVE_FLAG, DIFF_LOW_EVENT, DIFF_HIGH_EVENT};
    lvl_q   <= FIFO_LEVEL_COUNT;
    fl_q    <= {FIFO_LEVEL_COUNT >= {1'h0, FIFO_THRESHOLD},
                (FIFO_LEVEL_COUNT == 8'h80) && FIFO_OVERWRITTEN,
                (FIFO_LEVEL_COUNT == 8'h80) && !FIFO_OVERWRITTEN};
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // ****************************************
  // Assertions
  // ****************************************
  a_ref_high: assert property (REG_RD && REG_ADDR == 8'h16 |=> REG_RDATA == ref_q)
    else $error("reference high byte wrong");
  a_cause_byte: assert property (REG_RD && REG_ADDR == 8'h24 |=> REG_RDATA == cause_q)
    else $error("cause byte wrong");
  a_level_byte: assert property (REG_RD && REG_ADDR == 8'h25 |=> REG_RDATA == lvl_q)
    else $error("fifo level byte wrong");
  a_fifo_flags: assert property (REG_RD && REG_ADDR == 8'h26 |=> REG_RDATA[7:5] == fl_q)
    else $error("fifo flag bits wrong");
  a_trim_write: assert property (REG_WR && REG_ADDR == 8'h18 |=>
    PRESSURE_OFFSET_WORD[7:0] == $past(REG_WDATA))
    else $error("offset low byte not taken");
  a_filter_clear: assert property (REG_RD && REG_ADDR == 8'h3C |=>
    EXTRA_LOWPASS_FILTER_CLEAR)
    else $error("filter clear missing");
  a_filter_lone: assert property (!(REG_RD && REG_ADDR == 8'h3C) |=>
    !EXTRA_LOWPASS_FILTER_CLEAR)
    else $error("filter clear without read");
  a_pop_last: assert property (REG_RD && REG_ADDR == 8'h7C &&
    FIFO_LEVEL_COUNT != 8'h00 |=> FIFO_POP)
    else $error("fifo pop missing");
endmodule
bind prr_result_regs prr_chk u_chk (.REF_CLK(REF_CLK), .SRST(SRST), .REG_RD(REG_RD),
  .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .REFERENCE_PRESSURE_BITS(REFERENCE_PRESSURE_BITS), .BOOT_RUNNING(BOOT_RUNNING),
  .DIFF_LOW_EVENT(DIFF_LOW_EVENT), .DIFF_HIGH_EVENT(DIFF_HIGH_EVENT),
  .IRQ_ACTIVE_FLAG(IRQ_ACTIVE_FLAG), .FIFO_LEVEL_COUNT(FIFO_LEVEL_COUNT),
  .FIFO_THRESHOLD(FIFO_THRESHOLD), .FIFO_OVERWRITTEN(FIFO_OVERWRITTEN), .FIFO_POP(FIFO_POP),
  .EXTRA_LOWPASS_FILTER_CLEAR(EXTRA_LOWPASS_FILTER_CLEAR),
  .PRESSURE_OFFSET_WORD(PRESSURE_OFFSET_WORD));

// ### test/prr_fifo_model.sv
/* Model of the FIFO core: level count and oldest sample.
   Assumes the bench loads a level before use; head index moves on pop. */
`timescale 1ns/1ps
module prr_fifo_model (
  // Clock and control
  input wire logic        clk,
  input wire logic        load,
  input wire logic [7:0]  load_level,
  input wire logic        pop,
  // Level count and oldest sample
  output logic      [7:0] level,
  output logic     [23:0] head_p,
  output logic     [15:0] head_t
);
  logic [7:0] ptr;
  // Patterned head so a missed or doubled pop shows at once
  always @(posedge clk) begin
    if (load) begin
      level <= load_level;
      ptr <= 8'h00;
    end else if (pop && level != 8'h00) begin
      level <= level - 8'h01;
      ptr <= ptr + 8'h01;
    end
  end
  assign head_p = {ptr, 8'h5A, ~ptr};
  assign head_t = {8'hC3, ptr};
endmodule

// ### test/prr_result_regs_tb_top.sv
/* Self-checking bench of the result register block.
   Assumes the design, checker and FIFO model are compiled first. */
`timescale 1ns/1ps
module prr_result_regs_tb_top;
  logic clk, srst, rd, wr, hold, dm, zm, cm, ns, tk, boot, lo, hi, irq, ovw, pop, fclr, ld, pend;
  logic [7:0] addr, wdata, rdata, lvl, flvl;
  logic [15:0] refw, temp, off, offw, ht, e;
  logic [23:0] meas, prp, hp, ep;
  logic [39:0] wd;
  logic [6:0] thr;
  logic [15:0] expq[$];
  logic [7:0] lv[5] = '{8'h00, 8'h1F, 8'h20, 8'h80, 8'h80};
  int bad_count, total_checks, cyc;
  prr_result_regs dut (.REF_CLK(clk), .SRST(srst), .REG_RD(rd), .REG_WR(wr), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .BLOCK_UPDATE_HOLD(hold), .DELTA_MODE_ENABLE(dm),
    .ZERO_TRACKING_MODE(zm), .REF_CAPTURE_MODE(cm), .REFERENCE_PRESSURE_BITS(refw),
    .NEW_SAMPLE(ns), .MEASURED_PRESSURE(meas), .PROCESSED_PRESSURE(prp),
    .MEASURED_TEMPERATURE(temp), .OUTPUT_RATE_TICK(tk), .BOOT_RUNNING(boot),
    .DIFF_LOW_EVENT(lo), .DIFF_HIGH_EVENT(hi), .IRQ_ACTIVE_FLAG(irq), .FIFO_LEVEL_COUNT(lvl),
    .FIFO_THRESHOLD(thr), .FIFO_OVERWRITTEN(ovw), .FIFO_HEAD_PRESSURE(hp),
    .FIFO_HEAD_TEMPERATURE(ht), .FIFO_POP(pop), .EXTRA_LOWPASS_FILTER_CLEAR(fclr),
    .PRESSURE_OFFSET_WORD(offw));
  prr_fifo_model u_fifo (.clk(clk), .load(ld), .load_level(flvl), .pop(pop), .level(lvl),
    .head_p(hp), .head_t(ht));
  // ****************************************
  // Clock, timeout and result monitor
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [23:0] x, input logic [23:0] s);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    pend <= rd & ~srst;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // Read data stands until the next read, so the falling edge is safe
  always @(negedge clk) if (pend) begin
    e = expq.pop_front();
    chk("REG_RDATA", {16'h0000, e[7:0]}, {16'h0000, rdata & e[15:8]});
  end
  // ****************************************
  // Drivers, all at the falling edge
  // ****************************************
  task automatic rdc(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    rd = 1'b1;
    addr = a;
    expq.push_back({m, x & m});
    @(negedge clk) rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk) wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic smp;
    ns = 1'b1;
    @(negedge clk) ns = 1'b0;
    @(negedge clk);
  endtask
  task automatic tck;
    tk = 1'b1;
    @(negedge clk) tk = 1'b0;
    @(negedge clk);
  endtask
  task automatic fld(input logic [7:0] l);
    flvl = l;
    ld = 1'b1;
    @(negedge clk) ld = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {rd, wr, hold, dm, zm, cm, ns, tk, boot, lo, hi, irq, ovw, ld} = '0;
    {addr, wdata, flvl} = '0;
    srst = 1'b1;
    thr = 7'h20;
    void'($urandom(54509));
    refw = 16'($urandom);
    meas = 24'($urandom);
    prp = 24'($urandom);
    temp = 16'($urandom);
    off = 16'($urandom);
    fld(8'h00);
    repeat (19) @(negedge clk);
    srst = 1'b0;
    rdc(8'h3C, 8'h00, 8'hFF);
    rdc(8'h16, refw[15:8], 8'hFF);
    rdc(8'h18, 8'h00, 8'hFF);
    rdc(8'h19, 8'h00, 8'hFF);
    rdc(8'h30, 8'h00, 8'hFF);
    wrb(8'h18, off[7:0]);
    wrb(8'h19, off[15:8]);
    chk("PRESSURE_OFFSET_WORD", {8'h00, off}, {8'h00, offw});
    smp();
    meas = 24'($urandom);
    smp();
    tck();
    rdc(8'h27, 8'h33, 8'h33);
    ep = meas - {{8{off[15]}}, off};
    for (int j = 0; j < 3; j++) rdc(8'h28 + j[7:0], ep[8*j+:8], 8'hFF);
    rdc(8'h2B, temp[7:0], 8'hFF);
    rdc(8'h2C, temp[15:8], 8'hFF);
    tck();
    rdc(8'h27, 8'h00, 8'h33);
    hold = 1'b1;
    rdc(8'h28, ep[7:0], 8'hFF);
    meas = 24'($urandom);
    smp();
    rdc(8'h29, ep[15:8], 8'hFF);
    rdc(8'h2A, ep[23:16], 8'hFF);
    ep = meas - {{8{off[15]}}, off};
    repeat (2) @(negedge clk);
    rdc(8'h28, ep[7:0], 8'hFF);
    hold = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {dm, zm, cm} = 3'h1 << i;
      prp = 24'($urandom);
      smp();
      rdc(8'h28, prp[7:0], 8'hFF);
    end
    {dm, zm, cm} = 3'h0;
    repeat (8) begin
      {boot, irq, lo, hi} = 4'($urandom);
      rdc(8'h24, {boot, 4'h0, irq, lo, hi}, 8'hFF);
    end
    for (int i = 0; i < 5; i++) begin
      ovw = (i == 4);
      fld(lv[i]);
      rdc(8'h25, lv[i], 8'hFF);
      rdc(8'h26, {lv[i] >= {1'h0, thr}, (lv[i] == 8'h80) & ovw,
        (lv[i] == 8'h80) & ~ovw, 5'h00}, 8'hE0);
    end
    ovw = 1'b0;
    fld(8'h02);
    for (int k = 0; k < 2; k++) begin
      wd = {8'hC3, k[7:0], k[7:0], 8'h5A, ~k[7:0]};
      for (int j = 0; j < 5; j++) rdc(8'h78 + j[7:0], wd[8*j+:8], 8'hFF);
    end
    rdc(8'h25, 8'h00, 8'hFF);
    // Mid-run reset must drop the written offset back to zero
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk("PRESSURE_OFFSET_WORD", 24'h00_0000, {8'h00, offw});
    rdc(8'h19, 8'h00, 8'hFF);
    repeat (2) @(negedge clk);
    conclude();
  end
endmodule
